/* design/cts_defs.svh */
// Register offsets, field positions, reset values and codes for the channel transmit state block.
`ifndef CTS_DEFS_SVH
`define CTS_DEFS_SVH
`define CTS_CTRL 8'h00
`define CTS_CUR_RATE 8'h04
`define CTS_MIN_RATE 8'h08
`define CTS_BWD_PTR 8'h0C
`define CTS_TALLY_A 8'h10
`define CTS_TALLY_B 8'h14
`define CTS_THRESH_1 8'h18
`define CTS_THRESH_2 8'h1C
`define CTS_POOLS 8'h20
`define CTS_POOL_ID 8'h24
`define CTS_BYTES_Q 8'h28
`define CTS_PERIOD 8'h2C
`define CTS_STAMP 8'h30
`define CTS_DESC_PTR 8'h34
`define CTS_STATUS 8'h38
`define CTS_CLEAR 8'h3C
`define CTS_ENABLE 8'h40
`define CTS_NOW 8'h44
`define CTS_CTRL_SEL_A 1:0
`define CTS_CTRL_SEL_B 3:2
`define CTS_CTRL_KIND 5:4
`define CTS_CTRL_ARM 6
`define CTS_EV_WRAP_A 0
`define CTS_EV_WRAP_B 1
`define CTS_EV_BWD_SENT 2
`define CTS_EV_TIMER 3
`define CTS_SEL_CELLS 2'h0
`define CTS_SEL_BYTES 2'h1
`define CTS_SEL_FRAMES 2'h2
`define CTS_KIND_REL_ONCE 2'h0
`define CTS_KIND_REL_PERIOD 2'h1
`define CTS_KIND_ABS_ONCE 2'h2
`define CTS_KIND_ABS_PERIOD 2'h3
`define CTS_HTRANS_NONSEQ 2'h2
`define CTS_CTRL_RESET 7'h00
`define CTS_POOLS_RESET 24'h00_0000
`endif

/* design/cts_pkg.sv */
// Types shared by the channel transmit state block and its timer.
package cts_pkg;
    typedef struct packed {
        logic cell_sent;
        logic [6:0] cell_bytes;
        logic frame_sent;
        logic bwd_sent;
        logic enq_valid;
        logic [15:0] enq_bytes;
        logic rate_valid;
        logic [15:0] rate;
    } seg_events_t;

    typedef struct packed {
        logic valid;
        logic [31:0] ptr;
    } desc_req_t;

    typedef struct packed {
        logic [31:0] now;
        logic [31:0] deadline;
        logic armed;
        logic expire;
    } tmr_state_t;

    typedef struct packed {
        logic dph_wr;
        logic [7:0] dph_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic [6:0] ctrl;
        logic [15:0] cur_rate;
        logic [15:0] min_rate;
        logic [31:0] bwd_ptr;
        logic [31:0] tally_a;
        logic [31:0] tally_b;
        logic [23:0] th1;
        logic [23:0] th2;
        logic [23:0] pools;
        logic [7:0] pool_id;
        logic [31:0] bytes_q;
        logic [15:0] period;
        logic [31:0] stamp;
        logic [31:0] desc;
        logic [3:0] status;
        logic [3:0] irq_en;
        logic irq;
        logic arm;
        desc_req_t req;
    } cts_state_t;

    function automatic logic kind_periodic(input logic [1:0] kind);
        return kind == 2'h1 || kind == 2'h3;
    endfunction

    function automatic logic kind_relative(input logic [1:0] kind);
        return kind == 2'h0 || kind == 2'h1;
    endfunction
endpackage

/* design/cts_timer.sv */
// Timeslot clock and four-kind expiry timer for one connection.
`timescale 1ns/1ps
`include "cts_defs.svh"
module cts_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic arm,
    input wire logic [1:0] kind,
    input wire logic [15:0] period,
    input wire logic [31:0] stamp,
    output logic expire,
    output logic armed,
    output logic [31:0] now
);
    import cts_pkg::*;

    tmr_state_t s;
    tmr_state_t next_s;
    logic [31:0] per;

    assign per = (period == 16'h0000) ? 32'h0000_0001 : {16'h0000, period};

    always_comb begin
        next_s = s;
        next_s.expire = 1'b0;
        if (tick) begin
            next_s.now = s.now + 32'h0000_0001; // RULE_14
        end
        if (arm) begin
            next_s.armed = 1'b1;
            if (kind_relative(kind)) begin
                next_s.deadline = s.now + per; // RULE_10 RULE_11
            end else begin
                next_s.deadline = stamp; // RULE_12 RULE_13
            end
        end else if (s.armed && tick && next_s.now == s.deadline) begin
            next_s.expire = 1'b1;
            if (kind_periodic(kind)) begin
                next_s.deadline = s.deadline + per; // RULE_10 RULE_13
            end else begin
                next_s.armed = 1'b0; // RULE_11 RULE_12
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign expire = s.expire;
    assign armed = s.armed;
    assign now = s.now;

    periodic_rearm_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        s.expire && kind_periodic(kind) && !$past(arm) |-> s.armed
        && s.deadline == $past(s.deadline) + per)
        else $error("Periodic timer did not reschedule after expiry.");
    oneshot_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        s.expire && !kind_periodic(kind) |-> !s.armed)
        else $error("One-shot timer stayed armed after expiry.");
    rel_deadline_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_14
        arm && kind_relative(kind) |=> s.deadline == $past(s.now) + $past(per))
        else $error("Relative timer deadline is not one period ahead.");
    abs_expiry_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_12
        s.expire |-> s.now == $past(s.deadline))
        else $error("Timer expired away from its deadline.");
    periodic_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
        s.expire && kind == 2'h1);
endmodule

/* design/cts_block.sv */
// Connection transmit state: ABR rates, backward cell pointer, tallies, pool swap and timer.
`timescale 1ns/1ps
`include "cts_defs.svh"
// Function
// [RULE_01] Keep a 16-bit current ABR cell rate for the connection.
// [RULE_02] Keep a 16-bit ABR minimum cell rate for the connection.
// [RULE_03] Software posts the address of a ready backward RM cell buffer.
// [RULE_04] Clear the backward cell pointer to zero once that cell is sent.
// [RULE_05] Two 32-bit tallies each count cells, bytes or frames sent.
// [RULE_06] A tally wrapping past its maximum raises an event.
// [RULE_07] Software zeroes both tallies when it sets up the connection.
// [RULE_08] Keep a running count of bytes queued for transmission.
// [RULE_09] Compare two thresholds to queued bytes upper 24 bits; swap pool on crossing.
// [RULE_10] Kind 01 expires one period after scheduling and reschedules itself.
// [RULE_11] Relative one-shot kind expires after one period, then stops.
// [RULE_12] Absolute one-shot kind expires when time reaches the timestamp, then stops.
// [RULE_13] Absolute periodic kind expires at the timestamp, then repeats each period.
// [RULE_14] The timer period counts timeslots until expiry.
// [RULE_15] On expiry, queue the descriptor named by the timer's pointer.
// [RULE_16] Each tally has a setting choosing cells, bytes or frames.
module cts_block (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire cts_pkg::seg_events_t seg,
    input wire logic timeslot,
    output logic [15:0] cur_rate,
    output logic [15:0] min_rate,
    output logic [31:0] bwd_ptr,
    output logic [7:0] pool_id,
    output cts_pkg::desc_req_t desc_req,
    output logic irq
);
    import cts_pkg::*;

    logic [1:0] rst_sync;
    logic rst_core_n;
    cts_state_t s;
    cts_state_t next_s;
    logic addr_ok;
    logic tmr_expire;
    logic tmr_armed;
    logic [31:0] tmr_now;
    logic wr_bwd;
    logic wr_tally_a;
    logic wr_tally_b;
    logic [32:0] sum_a;
    logic [32:0] sum_b;
    logic [31:0] q_next;
    logic [7:0] pool_sel;
    logic pend;

    // Reset is released through two flip-flops so that all state leaves reset together.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync[1];

    function automatic logic [31:0] tally_step(input logic [1:0] sel, input seg_events_t ev);
        logic [31:0] inc;
        inc = 32'h0000_0000;
        case (sel)
            `CTS_SEL_CELLS: inc = {31'h0, ev.cell_sent};
            `CTS_SEL_BYTES: inc = ev.cell_sent ? {25'h0, ev.cell_bytes} : 32'h0000_0000;
            `CTS_SEL_FRAMES: inc = {31'h0, ev.frame_sent};
            default: inc = 32'h0000_0000;
        endcase
        return inc;
    endfunction

    function automatic logic [31:0] reg_read(input logic [7:0] a, input cts_state_t r,
                                             input logic [31:0] now);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            `CTS_CTRL: d = {25'h0, r.ctrl};
            `CTS_CUR_RATE: d = {16'h0000, r.cur_rate};
            `CTS_MIN_RATE: d = {16'h0000, r.min_rate};
            `CTS_BWD_PTR: d = r.bwd_ptr;
            `CTS_TALLY_A: d = r.tally_a;
            `CTS_TALLY_B: d = r.tally_b;
            `CTS_THRESH_1: d = {8'h00, r.th1};
            `CTS_THRESH_2: d = {8'h00, r.th2};
            `CTS_POOLS: d = {8'h00, r.pools};
            `CTS_POOL_ID: d = {24'h00_0000, r.pool_id};
            `CTS_BYTES_Q: d = r.bytes_q;
            `CTS_PERIOD: d = {16'h0000, r.period};
            `CTS_STAMP: d = r.stamp;
            `CTS_DESC_PTR: d = r.desc;
            `CTS_STATUS: d = {28'h000_0000, r.status};
            `CTS_ENABLE: d = {28'h000_0000, r.irq_en};
            `CTS_NOW: d = now;
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    cts_timer timer (
        .clk(clk),
        .rst_n(rst_core_n),
        .tick(timeslot),
        .arm(s.arm),
        .kind(s.ctrl[`CTS_CTRL_KIND]),
        .period(s.period),
        .stamp(s.stamp),
        .expire(tmr_expire),
        .armed(tmr_armed),
        .now(tmr_now)
    );

    assign addr_ok = hsel && hready && htrans == `CTS_HTRANS_NONSEQ;
    assign wr_bwd = s.dph_wr && s.dph_addr == `CTS_BWD_PTR;
    assign wr_tally_a = s.dph_wr && s.dph_addr == `CTS_TALLY_A;
    assign wr_tally_b = s.dph_wr && s.dph_addr == `CTS_TALLY_B;
    assign sum_a = {1'b0, s.tally_a} + {1'b0, tally_step(s.ctrl[`CTS_CTRL_SEL_A], seg)};
    assign sum_b = {1'b0, s.tally_b} + {1'b0, tally_step(s.ctrl[`CTS_CTRL_SEL_B], seg)};
    assign q_next = s.bytes_q + (seg.enq_valid ? {16'h0000, seg.enq_bytes} : 32'h0000_0000)
                    - (seg.cell_sent ? {25'h0, seg.cell_bytes} : 32'h0000_0000);
    assign pool_sel = (s.bytes_q[31:8] >= s.th2) ? s.pools[23:16] :
                      (s.bytes_q[31:8] >= s.th1) ? s.pools[15:8] : s.pools[7:0];
    assign pend = |(s.status & s.irq_en);

    always_comb begin
        next_s = s;
        next_s.hreadyout = 1'b1;
        next_s.arm = 1'b0;
        next_s.dph_wr = addr_ok && hwrite;
        next_s.dph_addr = addr_ok ? haddr[7:0] : 8'h00;
        if (addr_ok && !hwrite) begin
            next_s.hrdata = reg_read(haddr[7:0], s, tmr_now);
        end
        if (seg.rate_valid) begin
            next_s.cur_rate = seg.rate; // RULE_01
        end
        if (seg.bwd_sent) begin
            next_s.bwd_ptr = 32'h0000_0000; // RULE_04
        end
        next_s.tally_a = sum_a[31:0]; // RULE_05 RULE_16
        next_s.tally_b = sum_b[31:0]; // RULE_05 RULE_16
        next_s.bytes_q = q_next; // RULE_08
        next_s.pool_id = pool_sel; // RULE_09
        next_s.req.valid = tmr_expire; // RULE_15
        next_s.req.ptr = tmr_expire ? s.desc : s.req.ptr; // RULE_15
        if (s.dph_wr) begin
            case (s.dph_addr)
                `CTS_CTRL: begin
                    next_s.ctrl = hwdata[6:0];
                    next_s.arm = hwdata[`CTS_CTRL_ARM];
                end
                `CTS_CUR_RATE: next_s.cur_rate = hwdata[15:0]; // RULE_01
                `CTS_MIN_RATE: next_s.min_rate = hwdata[15:0]; // RULE_02
                `CTS_BWD_PTR: next_s.bwd_ptr = hwdata; // RULE_03
                `CTS_TALLY_A: next_s.tally_a = hwdata; // RULE_07
                `CTS_TALLY_B: next_s.tally_b = hwdata; // RULE_07
                `CTS_THRESH_1: next_s.th1 = hwdata[23:0];
                `CTS_THRESH_2: next_s.th2 = hwdata[23:0];
                `CTS_POOLS: next_s.pools = hwdata[23:0];
                `CTS_BYTES_Q: next_s.bytes_q = hwdata;
                `CTS_PERIOD: next_s.period = hwdata[15:0];
                `CTS_STAMP: next_s.stamp = hwdata;
                `CTS_DESC_PTR: next_s.desc = hwdata;
                `CTS_CLEAR: next_s.status = s.status & ~hwdata[3:0];
                `CTS_ENABLE: next_s.irq_en = hwdata[3:0];
                default: next_s.arm = 1'b0;
            endcase
        end
        // Hardware events are applied after the clear so that a set wins.
        if (sum_a[32] && !wr_tally_a) begin
            next_s.status[`CTS_EV_WRAP_A] = 1'b1; // RULE_06
        end
        if (sum_b[32] && !wr_tally_b) begin
            next_s.status[`CTS_EV_WRAP_B] = 1'b1; // RULE_06
        end
        if (seg.bwd_sent) begin
            next_s.status[`CTS_EV_BWD_SENT] = 1'b1;
        end
        if (tmr_expire) begin
            next_s.status[`CTS_EV_TIMER] = 1'b1;
        end
        next_s.irq = pend;
    end

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            s <= '0;
            s.ctrl <= `CTS_CTRL_RESET;
            s.pools <= `CTS_POOLS_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.hreadyout;
    assign hresp = 1'b0;
    assign cur_rate = s.cur_rate;
    assign min_rate = s.min_rate;
    assign bwd_ptr = s.bwd_ptr;
    assign pool_id = s.pool_id;
    assign desc_req = s.req;
    assign irq = s.irq;

    bwd_clear_a: assert property (@(posedge clk) disable iff (!rst_core_n) // RULE_04
        seg.bwd_sent && !wr_bwd |=> s.bwd_ptr == 32'h0000_0000 && s.status[2])
        else $error("Backward pointer not cleared after the cell was sent.");
    cell_tally_a: assert property (@(posedge clk) disable iff (!rst_core_n) // RULE_05
        s.ctrl[1:0] == 2'h0 && seg.cell_sent && !wr_tally_a
        |=> s.tally_a == $past(s.tally_a) + 32'h0000_0001)
        else $error("Cell tally did not advance by one.");
    wrap_event_a: assert property (@(posedge clk) disable iff (!rst_core_n) // RULE_06
        s.tally_b == 32'hFFFF_FFFF && s.ctrl[3:2] == 2'h2 && seg.frame_sent && !wr_tally_b
        |=> s.tally_b == 32'h0000_0000 && s.status[1])
        else $error("Tally wrap did not raise its event.");
    queue_count_a: assert property (@(posedge clk) disable iff (!rst_core_n) // RULE_08
        !s.dph_wr && seg.enq_valid && !seg.cell_sent
        |=> s.bytes_q == $past(s.bytes_q) + {16'h0000, $past(seg.enq_bytes)})
        else $error("Queued byte count did not follow an enqueue.");
    pool_swap_a: assert property (@(posedge clk) disable iff (!rst_core_n) // RULE_09
        s.bytes_q[31:8] >= s.th2 |=> s.pool_id == $past(s.pools[23:16]))
        else $error("Pool identifier not replaced above the second threshold.");
    desc_queue_a: assert property (@(posedge clk) disable iff (!rst_core_n) // RULE_15
        tmr_expire |=> s.req.valid && s.req.ptr == $past(s.desc) ##1 !s.req.valid)
        else $error("Timer expiry did not queue its descriptor for one cycle.");
    irq_level_a: assert property (@(posedge clk) disable iff (!rst_core_n)
        ##1 s.irq == $past(pend))
        else $error("Interrupt output does not follow enabled status.");
    rate_keep_a: assert property (@(posedge clk) disable iff (!rst_core_n) // RULE_01
        seg.rate_valid && !s.dph_wr |=> s.cur_rate == $past(seg.rate))
        else $error("Current rate not taken from the scheduler.");
    min_rate_a: assert property (@(posedge clk) disable iff (!rst_core_n) // RULE_02
        !s.dph_wr |=> $stable(s.min_rate))
        else $error("Minimum rate changed without a write.");
    bwd_cov_c: cover property (@(posedge clk) disable iff (!rst_core_n)
        wr_bwd ##[1:50] seg.bwd_sent);
    wrap_cov_c: cover property (@(posedge clk) disable iff (!rst_core_n)
        sum_a[32]);
    timer_cov_c: cover property (@(posedge clk) disable iff (!rst_core_n)
        tmr_expire && tmr_armed);
endmodule

/* testbench/cts_sched_model.sv */
// Scheduler-side model that pulses segmentation events and timeslots.
`timescale 1ns/1ps
module cts_sched_model (
    input wire logic clk,
    output cts_pkg::seg_events_t seg,
    output logic timeslot
);
    import cts_pkg::*;
    initial begin
        seg = '0;
        timeslot = 1'b0;
    end
    // Bits of k: 0 cell, 1 frame end, 2 backward cell, 3 enqueue; zero k posts a new rate.
    // Data fields are inverted afterwards so that a stale value never passes for a fresh one.
    task automatic post(input logic [3:0] k, input logic [15:0] v);
        seg_events_t e;
        seg_events_t idle;
        e = '0;
        e.cell_sent = k[0];
        e.cell_bytes = v[6:0];
        e.frame_sent = k[1];
        e.bwd_sent = k[2];
        e.enq_valid = k[3];
        e.enq_bytes = v;
        e.rate_valid = (k == 4'h0);
        e.rate = v;
        idle = '0;
        idle.cell_bytes = ~v[6:0];
        idle.enq_bytes = ~v;
        idle.rate = ~v;
        seg <= e;
        @(posedge clk);
        seg <= idle;
        @(posedge clk);
    endtask
    // Each timeslot is a one-cycle pulse followed by a quiet cycle.
    task automatic slots(input int unsigned n);
        repeat (n) begin
            timeslot <= 1'b1;
            @(posedge clk);
            timeslot <= 1'b0;
            @(posedge clk);
        end
    endtask
endmodule

/* testbench/channel_tx_state_stats_timer_tb.sv */
// Self-checking bench for the connection transmit state block.
`timescale 1ns/1ps
`include "cts_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
$display("wrong value %s expected %h seen %h", nm, e, g); end end
module channel_tx_state_stats_timer_tb;
    import cts_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, bwd_ptr, rv, last_ptr;
    logic hreadyout, hresp, timeslot, irq;
    logic [15:0] cur_rate, min_rate;
    logic [7:0] pool_id;
    seg_events_t seg;
    desc_req_t desc_req;
    int n_fail = 0;
    int n_checks = 0;
    int unsigned ts_cnt = 0;
    int unsigned exq[$];
    always #20 clk = ~clk;
    cts_block dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .seg(seg), .timeslot(timeslot),
        .cur_rate(cur_rate), .min_rate(min_rate), .bwd_ptr(bwd_ptr), .pool_id(pool_id),
        .desc_req(desc_req), .irq(irq));
    cts_sched_model sched (.clk(clk), .seg(seg), .timeslot(timeslot));
    always @(posedge clk) begin
        if (timeslot === 1'b1) ts_cnt <= ts_cnt + 1;
        if (desc_req.valid === 1'b1) begin
            exq.push_back(ts_cnt);
            last_ptr <= desc_req.ptr;
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        if (k >= 100) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= `CTS_HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rv = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0000_0000);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    function automatic int unsigned inc(input int sel, input int unsigned b, input bit fr);
        return sel == 0 ? 1 : sel == 1 ? b : sel == 2 ? int'(fr) : 0;
    endfunction
    function automatic logic [7:0] pick(input int unsigned q, input logic [23:0] pl);
        q = q >> 8;
        return q >= 'h30 ? pl[23:16] : q >= 'h10 ? pl[15:8] : pl[7:0];
    endfunction
    initial begin
        int unsigned ta, tq, bq, p, dl, e, t0;
        int sa, sb, i;
        logic [31:0] r;
        logic [23:0] pl;
        logic [6:0] b;
        bit fr;
        r = $urandom(46);
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        wait_ready();
        @(posedge clk);
        wr(8'h48, 32'hFFFF_FFFF);
        rd(8'h48);
        `CHK("unmapped", 32'h0000_0000, rv)
        `CHK("response", 1'b0, hresp)
        r = $urandom;
        wr(`CTS_CUR_RATE, r);
        wr(`CTS_MIN_RATE, ~r);
        rd(`CTS_CUR_RATE);
        `CHK("cur rate reg", {16'h0000, r[15:0]}, rv)
        `CHK("min rate out", ~r[15:0], min_rate)
        sched.post(4'h0, r[31:16]);
        settle();
        `CHK("cur rate out", r[31:16], cur_rate)
        rd(`CTS_MIN_RATE);
        `CHK("min rate reg", {16'h0000, ~r[15:0]}, rv)
        r = $urandom | 32'h0000_0001;
        wr(`CTS_BWD_PTR, r);
        settle();
        `CHK("bwd ptr out", r, bwd_ptr)
        wr(`CTS_CLEAR, 32'h0000_000F);
        sched.post(4'h4, 16'h0000);
        settle();
        `CHK("bwd ptr cleared", 32'h0000_0000, bwd_ptr)
        rd(`CTS_STATUS);
        `CHK("bwd sent flag", 32'h0000_0004, rv)
        for (sa = 0; sa < 3; sa++) begin
            sb = (sa + 1) % 3;
            wr(`CTS_CTRL, {28'h000_0000, sb[1:0], sa[1:0]});
            wr(`CTS_TALLY_A, 32'h0000_0000);
            wr(`CTS_TALLY_B, 32'h0000_0000);
            ta = 0;
            tq = 0;
            repeat (4) begin
                b = 7'($urandom);
                fr = 1'($urandom);
                sched.post({2'b00, fr, 1'b1}, {9'h000, b});
                ta += inc(sa, b, fr);
                tq += inc(sb, b, fr);
            end
            rd(`CTS_TALLY_A);
            `CHK("tally a", ta, rv)
            rd(`CTS_TALLY_B);
            `CHK("tally b", tq, rv)
        end
        wr(`CTS_CTRL, {28'h000_0000, `CTS_SEL_FRAMES, `CTS_SEL_CELLS});
        wr(`CTS_TALLY_A, 32'hFFFF_FFFE);
        wr(`CTS_TALLY_B, 32'hFFFF_FFFF);
        wr(`CTS_CLEAR, 32'h0000_000F);
        wr(`CTS_ENABLE, 32'h0000_0001);
        sched.post(4'h1, 16'h0001);
        settle();
        rd(`CTS_STATUS);
        `CHK("no wrap yet", 32'h0000_0000, rv)
        sched.post(4'h3, 16'h0001);
        settle();
        `CHK("irq on wrap", 1'b1, irq)
        rd(`CTS_STATUS);
        `CHK("both wrapped", 32'h0000_0003, rv)
        wr(`CTS_ENABLE, 32'h0000_0000);
        settle();
        `CHK("irq masked", 1'b0, irq)
        wr(`CTS_CLEAR, 32'h0000_0001);
        wr(`CTS_ENABLE, 32'h0000_0002);
        settle();
        `CHK("irq wrap b", 1'b1, irq)
        rd(`CTS_STATUS);
        `CHK("wrap b left", 32'h0000_0002, rv)
        wr(`CTS_CLEAR, 32'h0000_0002);
        settle();
        `CHK("irq cleared", 1'b0, irq)
        pl = 24'($urandom);
        wr(`CTS_POOLS, {8'h00, pl});
        wr(`CTS_THRESH_1, 32'h0000_0010);
        wr(`CTS_THRESH_2, 32'h0000_0030);
        wr(`CTS_BYTES_Q, 32'h0000_0000);
        bq = 0;
        repeat (14) begin
            r = $urandom % 32'h0000_1000;
            if (r[0]) begin
                sched.post(4'h8, r[15:0]);
                bq += r;
            end else begin
                sched.post(4'h1, {9'h000, r[7:1]});
                bq -= r[7:1];
            end
            settle();
            rd(`CTS_BYTES_Q);
            `CHK("bytes queued", bq, rv)
            `CHK("pool id", pick(bq, pl), pool_id)
        end
        wr(`CTS_ENABLE, 32'h0000_0008);
        for (i = 0; i < 4; i++) begin
            p = 2 + $urandom % 4;
            dl = 1 + $urandom % 5;
            r = $urandom;
            wr(`CTS_CLEAR, 32'h0000_000F);
            wr(`CTS_PERIOD, p);
            wr(`CTS_DESC_PTR, r);
            rd(`CTS_NOW);
            wr(`CTS_STAMP, rv + dl);
            exq.delete();
            t0 = ts_cnt;
            wr(`CTS_CTRL, {25'h000_0000, 1'b1, i[1:0], 4'h0});
            // The arm pulse must reach the timer before the first timeslot is counted.
            @(posedge clk);
            sched.slots(dl + 2 * p + 1);
            settle();
            e = t0 + (i < 2 ? p : dl);
            sa = 0;
            while (e <= t0 + dl + 2 * p + 1 && (sa == 0 || i % 2 == 1)) begin
                `CHK("expiry slot", e, exq[sa])
                e += p;
                sa++;
            end
            `CHK("expiry count", sa, exq.size())
            `CHK("descriptor", r, last_ptr)
            `CHK("irq on expiry", 1'b1, irq)
        end
        conclude();
    end
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        conclude();
    end
endmodule
